// file: rtl/fcif_top.sv
// Four-channel filtered digital input with LEDs and a read-only input byte.
// Assumes asynchronous process inputs, and a bus side that samples the byte.
// Assumes the LED drivers and the bus coupler sit outside, on the same clock.
`timescale 1ns/1ps
`default_nettype none
module fcif_top
    import fcif_pkg::*;
#(
    parameter int FILTER_CYC     = FCIF_FILTER_CYC,
    parameter int FLASH_HALF_CYC = FCIF_FLASH_HALF_CYC
) (
    input  wire logic                   sys_clk,
    input  wire logic                   reset,
    input  wire logic [FCIF_NUM_CH-1:0] input_channel_n,
    input  wire logic                   config_error,
    input  wire logic                   bus_ok,
    output var  logic [FCIF_BYTE_W-1:0] input_state_byte,
    output var  logic [FCIF_NUM_CH-1:0] channel_led,
    output var  logic                   run_indicator,
    output var  logic                   module_fault_indicator
);
    localparam int CW = $clog2(FILTER_CYC + 1);
    localparam int FW = $clog2(FLASH_HALF_CYC + 1);

    logic [FCIF_NUM_CH-1:0] sync1_q, sync2_q, state_q;
    logic                   cfg1_q, cfg2_q, bok1_q, bok2_q;
    logic [FW-1:0]          flash_cnt_q;
    logic                   flash_q;
    wire                    flash_wrap = (flash_cnt_q == FW'(FLASH_HALF_CYC - 1));

    // Two-stage synchronisers; first stage feeds only the second
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            sync1_q <= '0;
            sync2_q <= '0;
            cfg1_q  <= 1'b0;
            cfg2_q  <= 1'b0;
            bok1_q  <= 1'b0;
            bok2_q  <= 1'b0;
        end else begin
            sync1_q <= input_channel_n;
            sync2_q <= sync1_q;
            cfg1_q  <= config_error;
            cfg2_q  <= cfg1_q;
            bok1_q  <= bus_ok;
            bok2_q  <= bok1_q;
        end
    end

    // Each channel has its own filter so all four run at once
    genvar g;
    generate
        for (g = 0; g < FCIF_NUM_CH; g++) begin : g_ch
            logic [CW-1:0] cnt_q;
            wire           differs = (sync2_q[g] != state_q[g]);
            wire           expired = (cnt_q == CW'(FILTER_CYC - 1));
            // Any bounce restarts the delay, so glitches never reach the byte
            always_ff @(posedge sys_clk) begin
                if (reset) begin
                    cnt_q      <= '0;
                    state_q[g] <= 1'b0;
                end else if (!differs) begin
                    cnt_q <= '0;
                end else if (expired) begin
                    cnt_q      <= '0;
                    state_q[g] <= sync2_q[g];
                end else begin
                    cnt_q <= cnt_q + CW'(1);
                end
            end
        end
    endgenerate

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            flash_cnt_q <= '0;
            flash_q     <= 1'b0;
        end else if (flash_wrap) begin
            flash_cnt_q <= '0;
            flash_q     <= ~flash_q;
        end else begin
            flash_cnt_q <= flash_cnt_q + FW'(1);
        end
    end

    // Outputs registered; no write path and no interrupt exist
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            input_state_byte       <= '0;
            channel_led            <= '0;
            run_indicator          <= 1'b0;
            module_fault_indicator <= 1'b0;
        end else begin
            input_state_byte       <= {FCIF_RESERVED_ZERO, state_q};
            // LED power independence is board level; logic only mirrors state
            channel_led            <= state_q;
            run_indicator          <= bok2_q;
            module_fault_indicator <= cfg2_q & flash_q;
        end
    end

    property p_reserved_zero;
        @(posedge sys_clk) disable iff (reset) input_state_byte[7:4] == FCIF_RESERVED_ZERO;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits not zero");

    property p_byte_tracks;
        @(posedge sys_clk) disable iff (reset)
            input_state_byte[FCIF_NUM_CH-1:0] == $past(state_q);
    endproperty
    a_byte_tracks: assert property (p_byte_tracks) else $error("byte does not follow state");

    property p_led_matches;
        @(posedge sys_clk) disable iff (reset) channel_led == input_state_byte[FCIF_NUM_CH-1:0];
    endproperty
    a_led_matches: assert property (p_led_matches) else $error("led differs from state");

    property p_rise_held;
        @(posedge sys_clk) disable iff (reset)
            $rose(state_q[0]) |-> $past(sync2_q[0], 1) && $past(sync2_q[0], 7);
    endproperty
    a_rise_held: assert property (p_rise_held) else $error("rise without stable input");

    property p_fall_held;
        @(posedge sys_clk) disable iff (reset)
            $fell(state_q[0]) |-> !$past(sync2_q[0], 1) && !$past(sync2_q[0], 7);
    endproperty
    a_fall_held: assert property (p_fall_held) else $error("fall without stable input");

    property p_no_change_equal;
        @(posedge sys_clk) disable iff (reset)
            (sync2_q == state_q) |=> $stable(state_q);
    endproperty
    a_no_change_equal: assert property (p_no_change_equal) else $error("state moved without cause");

    property p_fault_dark;
        @(posedge sys_clk) disable iff (reset) !cfg2_q |=> !module_fault_indicator;
    endproperty
    a_fault_dark: assert property (p_fault_dark) else $error("fault led lit without error");

    property p_fault_flash;
        @(posedge sys_clk) disable iff (reset)
            (cfg2_q && flash_q) |=> module_fault_indicator;
    endproperty
    a_fault_flash: assert property (p_fault_flash) else $error("fault led not flashing");

    c_rise: cover property (@(posedge sys_clk) disable iff (reset) $rose(state_q[0]));
    c_fall: cover property (@(posedge sys_clk) disable iff (reset) $fell(state_q[3]));
    c_all:  cover property (@(posedge sys_clk) disable iff (reset) state_q == '1);
    c_flash: cover property (@(posedge sys_clk) disable iff (reset) $rose(module_fault_indicator));
    c_glitch: cover property (@(posedge sys_clk) disable iff (reset)
        (g_ch[0].cnt_q != '0) ##1 (g_ch[0].cnt_q == '0) ##1 $stable(state_q[0]));

    // Checks below watch only state that this block drives itself
    property p_byte_stable;
        @(posedge sys_clk) disable iff (reset)
            $stable(state_q) |=> $stable(input_state_byte);
    endproperty
    a_byte_stable: assert property (p_byte_stable) else $error("byte moved without state change");

    property p_sync_chain;
        @(posedge sys_clk) disable iff (reset)
            sync2_q == $past(sync1_q);
    endproperty
    a_sync_chain: assert property (p_sync_chain) else $error("synchroniser stage skipped");

    property p_cfg_chain;
        @(posedge sys_clk) disable iff (reset)
            cfg2_q == $past(cfg1_q);
    endproperty
    a_cfg_chain: assert property (p_cfg_chain) else $error("error synchroniser stage skipped");

    property p_flash_wrap;
        @(posedge sys_clk) disable iff (reset)
            flash_wrap |=> (flash_cnt_q == '0);
    endproperty
    a_flash_wrap: assert property (p_flash_wrap) else $error("flash counter did not wrap");

    property p_flash_toggle;
        @(posedge sys_clk) disable iff (reset)
            flash_wrap |=> (flash_q != $past(flash_q));
    endproperty
    a_flash_toggle: assert property (p_flash_toggle) else $error("flash phase did not toggle");

    // The channel-0 checks are repeated per channel, since a slip in the
    // filter loop would otherwise only show on channels 1 to 3
    generate
        for (g = 0; g < FCIF_NUM_CH; g++) begin : g_chk
            property p_ch_rise;
                @(posedge sys_clk) disable iff (reset)
                    $rose(state_q[g]) |-> $past(sync2_q[g], 1) && $past(sync2_q[g], 7);
            endproperty
            a_ch_rise: assert property (p_ch_rise) else $error("channel rose without stable input");

            property p_ch_fall;
                @(posedge sys_clk) disable iff (reset)
                    $fell(state_q[g]) |-> !$past(sync2_q[g], 1) && !$past(sync2_q[g], 7);
            endproperty
            a_ch_fall: assert property (p_ch_fall) else $error("channel fell without stable input");

            // A count past its end would stretch the filter delay
            property p_cnt_bound;
                @(posedge sys_clk) disable iff (reset) g_ch[g].cnt_q <= CW'(FILTER_CYC - 1);
            endproperty
            a_cnt_bound: assert property (p_cnt_bound) else $error("filter counter out of range");

            // Agreement parks the counter, so a bounce restarts the delay
            property p_cnt_idle;
                @(posedge sys_clk) disable iff (reset)
                    (sync2_q[g] == state_q[g]) |=> (g_ch[g].cnt_q == '0);
            endproperty
            a_cnt_idle: assert property (p_cnt_idle) else $error("filter counter not restarted");

            property p_bit_lag;
                @(posedge sys_clk) disable iff (reset)
                    input_state_byte[g] == $past(state_q[g]);
            endproperty
            a_bit_lag: assert property (p_bit_lag) else $error("channel bit in wrong place");
        end
    endgenerate
endmodule
`default_nettype wire

// file: common/fcif_pkg.sv
// Constants and types of the four-channel input filter.
// Assumes a 40 MHz system clock; counts below are derived from it.
//
// Notes on behaviour
// - Four inputs sampled; channel n reported in bit n of the input byte.
// - Block owns no output bytes; the bus never writes process data here.
// - A low-to-high change is reported only after a 3 ms filter delay.
// - A high-to-low change is reported only after a 3 ms filter delay.
// - No interrupts, no alarms, no diagnostic data for read-out.
// - One green indicator per channel follows that channel's reported state.
// - Red fault indicator flashes while a configuration error is present.
// - All four channels usable at once, in any mounting orientation.
package fcif_pkg;
    localparam int          FCIF_CLK_HZ        = 40_000_000;
    localparam int          FCIF_NUM_CH        = 4;
    localparam int          FCIF_BYTE_W        = 8;
    localparam logic [7:0]  FCIF_INPUT_OFFSET  = 8'h00;
    localparam int          FCIF_FILTER_US     = 3000;
    // Least time: whole cycles, no rounding up; the MHz divide truncates
    localparam int          FCIF_FILTER_CYC    = (FCIF_FILTER_US * (FCIF_CLK_HZ / 1_000_000) + 0);
    localparam int          FCIF_FLASH_HZ      = 2;
    localparam int          FCIF_FLASH_HALF_CYC = FCIF_CLK_HZ / (2 * FCIF_FLASH_HZ);
    localparam logic [3:0]  FCIF_RESERVED_ZERO = 4'h0;
endpackage

// file: testbench/fcif_reader.sv
// Bus-side reader model: samples the input byte once per clock.
// Assumes the byte is a settled registered level at each rising edge.
`timescale 1ns/1ps
`default_nettype none
module fcif_reader
    import fcif_pkg::*;
(
    input  wire logic                   sys_clk,
    input  wire logic [FCIF_BYTE_W-1:0] input_state_byte,
    output var  logic [FCIF_BYTE_W-1:0] read_byte
);
    // Read only: the reader has no path to write process data
    always_ff @(posedge sys_clk) begin
        read_byte <= input_state_byte;
    end
endmodule
`default_nettype wire

// file: testbench/fcif_tb_top.sv
// Bench for the filtered input block, read through the reader model.
// Assumes short filter and flash counts so the run stays brief.
`timescale 1ns/1ps
`default_nettype none
module fcif_tb_top;
    import fcif_pkg::*;
    logic       sys_clk = 0, reset = 1, config_error = 0, bus_ok = 0;
    logic [3:0] input_channel_n = 4'h0;
    logic [7:0] input_state_byte, read_byte;
    logic [3:0] channel_led;
    logic       run_indicator, module_fault_indicator;
    logic       seen_on = 0, seen_off = 0;
    int         errors = 0, n_compared = 0, cycles = 0;
    always #12.5 sys_clk = ~sys_clk;
    fcif_top #(.FILTER_CYC(8), .FLASH_HALF_CYC(4)) dut (.sys_clk(sys_clk), .reset(reset),
        .input_channel_n(input_channel_n), .config_error(config_error), .bus_ok(bus_ok),
        .input_state_byte(input_state_byte), .channel_led(channel_led),
        .run_indicator(run_indicator), .module_fault_indicator(module_fault_indicator));
    fcif_reader reader (.sys_clk(sys_clk), .input_state_byte(input_state_byte), .read_byte(read_byte));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic finish_test;
        $display("compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Whole run needs about 80 cycles
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 400) begin
            errors++;
            finish_test();
        end
    end
    initial begin
        step(2);
        reset = 0;
        step(1);
        chk(read_byte, 8'h00);
        chk({7'h0, run_indicator}, 8'h00);
        input_channel_n = 4'h5;
        step(6);
        chk(read_byte, 8'h00);
        step(8);
        chk(read_byte, 8'h05);
        chk({4'h0, channel_led}, 8'h05);
        $display("test rise done");
        // Two channels fall while two rise, all at once
        input_channel_n = 4'hA;
        step(6);
        chk(read_byte, 8'h05);
        step(8);
        chk(read_byte, 8'h0A);
        chk({4'h0, channel_led}, 8'h0A);
        $display("test swap done");
        // A pulse shorter than the filter must vanish
        input_channel_n = 4'hF;
        step(3);
        input_channel_n = 4'hA;
        step(16);
        chk(read_byte, 8'h0A);
        $display("test glitch done");
        config_error = 1;
        bus_ok = 1;
        repeat (20) begin
            step(1);
            seen_on = seen_on | (module_fault_indicator === 1'b1);
            seen_off = seen_off | (module_fault_indicator === 1'b0);
        end
        chk({6'h0, seen_on, seen_off}, 8'h03);
        chk({7'h0, run_indicator}, 8'h01);
        config_error = 0;
        step(8);
        chk({7'h0, module_fault_indicator}, 8'h00);
        chk(read_byte, 8'h0A);
        $display("test fault done");
        finish_test();
    end
endmodule
`default_nettype wire
